// ---- core/hspp_pkg.sv ----
// Purpose: constants for the handshake parallel port block
// Assumes: 200 MHz clk, classic Wishbone slave, byte-wide registers in bits 7:0
// Notes:   offsets are byte addresses of aligned 32-bit words
package hspp_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] HSPP_OFF_PORT_CFG = 8'h00;
    localparam logic [7:0] HSPP_OFF_IRQ_CFG  = 8'h04;
    localparam logic [7:0] HSPP_OFF_STATUS   = 8'h08;
    localparam logic [7:0] HSPP_OFF_DESIRED_VALUE_A     = 8'h0C;
    localparam logic [7:0] HSPP_OFF_PAL      = 8'h10;

    // ------------------------------------------------------------
    // port_config_reg fields
    // ------------------------------------------------------------
    localparam int HSPP_CFG_MODE_LSB = 0;
    localparam int HSPP_CFG_EDGE_BIT = 3;
    localparam int HSPP_CFG_POL_BIT  = 4;
    localparam int HSPP_CFG_PLS_BIT  = 5;
    localparam int HSPP_CFG_TRI_BIT  = 6;

    // ------------------------------------------------------------
    // irq_config_reg fields
    // ------------------------------------------------------------
    localparam int HSPP_ICR_ENB_BIT  = 0;
    localparam int HSPP_ICR_ENA_BIT  = 1;
    localparam int HSPP_ICR_TXIE_BIT = 3;
    localparam int HSPP_ICR_RXIE_BIT = 4;

    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int HSPP_ST_RX_BIT    = 0;
    localparam int HSPP_ST_TX_BIT    = 1;
    localparam int HSPP_ST_RXIRQ_BIT = 2;
    localparam int HSPP_ST_TXIRQ_BIT = 3;

    // ------------------------------------------------------------
    // handshake modes
    // ------------------------------------------------------------
    localparam logic [2:0] HSPP_MODE_MULTI  = 3'h4;
    localparam logic [2:0] HSPP_MODE_SINGLE = 3'h5;
    localparam logic [2:0] HSPP_MODE_OUTPUT = 3'h6;
    localparam logic [2:0] HSPP_MODE_BIDIR  = 3'h7;

    // ------------------------------------------------------------
    // reset values and fault-off masks
    // ------------------------------------------------------------
    localparam logic [7:0] HSPP_RST_PORT_CFG = 8'h00;
    localparam logic [7:0] HSPP_RST_IRQ_CFG  = 8'h00;
    localparam logic [7:0] HSPP_RST_DESIRED_VALUE_A     = 8'h00;
    localparam logic [7:0] HSPP_FAULT_ALL    = 8'hFF;
    localparam logic [7:0] HSPP_FAULT_B76    = 8'hC0;
    localparam logic [7:0] HSPP_FAULT_B74    = 8'hF0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int HSPP_CLK_PERIOD_NS = 5;
    localparam int HSPP_PULSE_MIN_NS  = 250;
    localparam logic [6:0] HSPP_PULSE_CYC =
        7'((HSPP_PULSE_MIN_NS + HSPP_CLK_PERIOD_NS - 1) / HSPP_CLK_PERIOD_NS);

endpackage

// ---- core/hspp_port.sv ----
// Purpose: handshake parallel port, port A data path with port B handshake pins
// Assumes: pins asynchronous to clk; Wishbone classic slave with one wait state
// Notes:   all pin inputs pass two flip-flops before any logic reads them
//
// How it works
// - mode 101 runs port A as single-read input, strobe on pb7, ready on pb6.
// - external writer drives port A and strobes; latch captures on selected edge.
// - ready output says data may be written; host latch read resets it.
// - strobe sets receive flag; while set, further external writes are blocked.
// - receive flag readable in status and drives interrupt when enabled.
// - single-read: pulse_sel high gives level tracking flag, low gives a pulse.
// - single-read disables fault monitoring on port A and pb7, pb6.
// - mode 100: each host read of port A emits a strobe_out pulse on pb6.
// - mode 110 drives port A from desired_value_a, volatile only.
// - output mode asserts rx_full_out on pb5 when new data is written.
// - output mode: external strobe after reading sets tx_empty_flag.
// - output mode: pulse_sel high tracks tx_empty_flag, low pulses.
// - output mode: tristate_disable keeps port A driven; faults off on port A, pb7, pb6.
// - mode 111 pins: pb7 read/write, pb6 ready, pb5 full, pb4 enable.
// - bidir: host write of desired value clears empty flag, asserts full.
// - bidir: enable high floats port A; enable low with read drives it.
// - bidir: enable low with write low latches port A at end, sets flag.
// - bidir: host latch read clears receive flag; flag raises interrupt.
// - bidir: external read sets empty flag, which raises interrupt when enabled.
// - bidir: pulse_sel low interlocks outputs with flags, high pulses them.
// - bidir: handshake_polarity sets level of both handshake outputs.
// - unmasked condition sets error flag; output driven only when enabled.
// - strobe_edge_sel 0 means falling edge, 1 means rising edge.
// - handshake_polarity 0 means active low outputs, 1 active high.
// - rx_irq_en gates receive flag onto interrupt output.
`timescale 1ns/1ps

module hspp_port (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [7:0]  port_a_i,
    output logic      [7:0]  port_a_o,
    output logic             port_a_oe_n,
    input  wire logic        pb7_i,
    input  wire logic        pb4_i,
    output logic             pb6_o,
    output logic             pb6_oe_n,
    output logic             pb5_o,
    output logic             pb5_oe_n,
    output logic             irq_a_out_n,
    output logic             irq_b_out_n,
    output logic      [7:0]  fault_off_a,
    output logic      [7:0]  fault_off_b
);
    import hspp_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  pa_s1;
        logic [7:0]  pa_s2;
        logic [7:0]  pa_s3;
        logic [2:0]  pb7_s;
        logic [2:0]  pb4_s;
        logic [7:0]  port_cfg;
        logic [7:0]  irq_cfg;
        logic [7:0]  desired_value_a;
        logic [7:0]  port_a_latch;
        logic        rx_ready;
        logic        tx_empty;
        logic        rx_irq;
        logic        tx_irq;
        logic [6:0]  cnt6;
        logic [6:0]  cnt5;
        logic        ack;
        logic [31:0] dat;
        logic [7:0]  pa_o;
        logic        pa_oe_n;
        logic        p6;
        logic        p6_oe_n;
        logic        p5;
        logic        p5_oe_n;
        logic        irq_a_n;
        logic        irq_b_n;
        logic [7:0]  f_a;
        logic [7:0]  f_b;
    } hspp_state_t;

    hspp_state_t state_reg;
    hspp_state_t state_next;

    // ------------------------------------------------------------
    // decoded events
    // ------------------------------------------------------------
    logic [2:0] mode;
    logic       edge_sel;
    logic       pol;
    logic       pulse_sel;
    logic       tri_dis;
    logic       req;
    logic       rd_pal;
    logic       wr_desired_value_a;
    logic       str_ev;
    logic       wr_end;
    logic       rd_end;
    logic       set_rx;
    logic       clr_rx;
    logic       set_tx;
    logic       clr_tx;

    assign mode     = state_reg.port_cfg[HSPP_CFG_MODE_LSB +: 3];
    assign edge_sel = state_reg.port_cfg[HSPP_CFG_EDGE_BIT];
    assign pol      = state_reg.port_cfg[HSPP_CFG_POL_BIT];
    assign pulse_sel      = state_reg.port_cfg[HSPP_CFG_PLS_BIT];
    assign tri_dis  = state_reg.port_cfg[HSPP_CFG_TRI_BIT];
    // side effects happen on the edge where the master sees ack
    assign req      = wb_cyc_i & wb_stb_i & state_reg.ack;
    assign rd_pal   = req & ~wb_we_i & (wb_adr_i == HSPP_OFF_PAL);
    assign wr_desired_value_a  = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == HSPP_OFF_DESIRED_VALUE_A);
    // edge detection looks at stages two and three only
    assign str_ev   = edge_sel ? (state_reg.pb7_s[1] & ~state_reg.pb7_s[2])
                               : (~state_reg.pb7_s[1] & state_reg.pb7_s[2]);
    assign wr_end   = (~state_reg.pb4_s[2] & ~state_reg.pb7_s[2])
                    & ~(~state_reg.pb4_s[1] & ~state_reg.pb7_s[1]);
    assign rd_end   = ~state_reg.pb4_s[2] & state_reg.pb7_s[2] & state_reg.pb4_s[1];

    assign set_rx   = ((mode == HSPP_MODE_SINGLE) & str_ev & ~state_reg.rx_ready)
                    | ((mode == HSPP_MODE_BIDIR) & wr_end);
    assign clr_rx   = rd_pal & ((mode == HSPP_MODE_SINGLE) | (mode == HSPP_MODE_BIDIR));
    assign set_tx   = ((mode == HSPP_MODE_OUTPUT) & str_ev)
                    | ((mode == HSPP_MODE_BIDIR) & rd_end);
    assign clr_tx   = wr_desired_value_a & ((mode == HSPP_MODE_OUTPUT) | (mode == HSPP_MODE_BIDIR));

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] rbyte;
        logic       act6;
        logic       act5;
        rbyte = 8'h00;
        act6 = 1'b0;
        act5 = 1'b0;
        state_next = state_reg;

        state_next.pa_s1 = port_a_i;
        state_next.pa_s2 = state_reg.pa_s1;
        state_next.pa_s3 = state_reg.pa_s2;
        state_next.pb7_s = {state_reg.pb7_s[1:0], pb7_i};
        state_next.pb4_s = {state_reg.pb4_s[1:0], pb4_i};

        // bus slave: one wait state, unmapped reads return zero
        state_next.ack = wb_cyc_i & wb_stb_i & ~state_reg.ack;
        state_next.dat = 32'h0000_0000;
        if (wb_cyc_i & wb_stb_i & ~state_reg.ack & ~wb_we_i) begin
            if (wb_adr_i == HSPP_OFF_PORT_CFG) begin
                rbyte = state_reg.port_cfg;
            end else if (wb_adr_i == HSPP_OFF_IRQ_CFG) begin
                rbyte = state_reg.irq_cfg;
            end else if (wb_adr_i == HSPP_OFF_STATUS) begin
                rbyte[HSPP_ST_RX_BIT]    = state_reg.rx_ready;
                rbyte[HSPP_ST_TX_BIT]    = state_reg.tx_empty;
                rbyte[HSPP_ST_RXIRQ_BIT] = state_reg.rx_irq;
                rbyte[HSPP_ST_TXIRQ_BIT] = state_reg.tx_irq;
            end else if (wb_adr_i == HSPP_OFF_DESIRED_VALUE_A) begin
                rbyte = state_reg.desired_value_a;
            end else if (wb_adr_i == HSPP_OFF_PAL) begin
                // multiple-read mode returns the live pins, not a held byte
                rbyte = (mode == HSPP_MODE_MULTI) ? state_reg.pa_s2 : state_reg.port_a_latch;
            end
            state_next.dat = {24'h00_0000, rbyte};
        end

        if (req & wb_we_i & wb_sel_i[0]) begin
            if (wb_adr_i == HSPP_OFF_PORT_CFG) begin
                state_next.port_cfg = wb_dat_i[7:0];
            end else if (wb_adr_i == HSPP_OFF_IRQ_CFG) begin
                state_next.irq_cfg = wb_dat_i[7:0];
            end else if (wb_adr_i == HSPP_OFF_DESIRED_VALUE_A) begin
                state_next.desired_value_a = wb_dat_i[7:0];
            end
        end

        // port A latch
        if ((mode == HSPP_MODE_SINGLE) & str_ev & ~state_reg.rx_ready) begin
            state_next.port_a_latch = state_reg.pa_s2;
        end else if ((mode == HSPP_MODE_BIDIR) & wr_end) begin
            state_next.port_a_latch = state_reg.pa_s3;
        end else if ((mode == HSPP_MODE_MULTI) & rd_pal) begin
            state_next.port_a_latch = state_reg.pa_s2;
        end

        // a set in the same cycle as a clear wins
        state_next.rx_ready = set_rx | (state_reg.rx_ready & ~clr_rx);
        state_next.tx_empty = set_tx | (state_reg.tx_empty & ~clr_tx);

        // interrupt error flags follow their unmasked condition
        state_next.rx_irq = state_reg.rx_ready & state_reg.irq_cfg[HSPP_ICR_RXIE_BIT];
        state_next.tx_irq = state_reg.tx_empty & state_reg.irq_cfg[HSPP_ICR_TXIE_BIT];
        state_next.irq_a_n = ~((state_reg.rx_irq | state_reg.tx_irq)
                               & state_reg.irq_cfg[HSPP_ICR_ENA_BIT]);
        state_next.irq_b_n = ~((state_reg.rx_irq | state_reg.tx_irq)
                               & state_reg.irq_cfg[HSPP_ICR_ENB_BIT]);

        // pulse timers, retriggered by each event
        if (((mode == HSPP_MODE_SINGLE) | (mode == HSPP_MODE_MULTI) | (mode == HSPP_MODE_BIDIR)) & rd_pal) begin
            state_next.cnt6 = HSPP_PULSE_CYC;
        end else if (state_reg.cnt6 != 7'd0) begin
            state_next.cnt6 = state_reg.cnt6 - 7'd1;
        end
        if (clr_tx) begin
            state_next.cnt5 = HSPP_PULSE_CYC;
        end else if (state_reg.cnt5 != 7'd0) begin
            state_next.cnt5 = state_reg.cnt5 - 7'd1;
        end

        state_next.p6_oe_n = 1'b1;
        state_next.p5_oe_n = 1'b1;
        state_next.pa_oe_n = 1'b1;
        state_next.pa_o    = state_reg.desired_value_a;
        state_next.f_a     = 8'h00;
        state_next.f_b     = 8'h00;
        case (mode)
            HSPP_MODE_SINGLE: begin
                act6 = pulse_sel ? ~state_reg.rx_ready : (state_reg.cnt6 != 7'd0);
                state_next.p6_oe_n = 1'b0;
                state_next.f_a = HSPP_FAULT_ALL;
                state_next.f_b = HSPP_FAULT_B76;
            end
            HSPP_MODE_MULTI: begin
                act6 = (state_reg.cnt6 != 7'd0);
                state_next.p6_oe_n = 1'b0;
            end
            HSPP_MODE_OUTPUT: begin
                act5 = pulse_sel ? ~state_reg.tx_empty : (state_reg.cnt5 != 7'd0);
                state_next.p5_oe_n = 1'b0;
                // without tristate_disable the port floats once the byte was taken
                state_next.pa_oe_n = ~(tri_dis | ~state_reg.tx_empty);
                state_next.f_a = HSPP_FAULT_ALL;
                state_next.f_b = HSPP_FAULT_B76;
            end
            HSPP_MODE_BIDIR: begin
                act6 = pulse_sel ? (state_reg.cnt6 != 7'd0) : ~state_reg.rx_ready;
                act5 = pulse_sel ? (state_reg.cnt5 != 7'd0) : ~state_reg.tx_empty;
                state_next.p6_oe_n = 1'b0;
                state_next.p5_oe_n = 1'b0;
                state_next.pa_oe_n = ~(~state_reg.pb4_s[1] & state_reg.pb7_s[1]);
                state_next.f_a = HSPP_FAULT_ALL;
                state_next.f_b = HSPP_FAULT_B74;
            end
            default: begin
                act6 = 1'b0;
            end
        endcase
        state_next.p6 = pol ? act6 : ~act6;
        state_next.p5 = pol ? act5 : ~act5;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg          <= '0;
            state_reg.pb7_s    <= 3'h7;
            state_reg.pb4_s    <= 3'h7;
            state_reg.port_cfg <= HSPP_RST_PORT_CFG;
            state_reg.irq_cfg  <= HSPP_RST_IRQ_CFG;
            state_reg.desired_value_a     <= HSPP_RST_DESIRED_VALUE_A;
            state_reg.tx_empty <= 1'b1;
            state_reg.pa_oe_n  <= 1'b1;
            state_reg.p6_oe_n  <= 1'b1;
            state_reg.p5_oe_n  <= 1'b1;
            state_reg.p6       <= 1'b1;
            state_reg.p5       <= 1'b1;
            state_reg.irq_a_n  <= 1'b1;
            state_reg.irq_b_n  <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign wb_dat_o    = state_reg.dat;
    assign wb_ack_o    = state_reg.ack;
    assign port_a_o    = state_reg.pa_o;
    assign port_a_oe_n = state_reg.pa_oe_n;
    assign pb6_o       = state_reg.p6;
    assign pb6_oe_n    = state_reg.p6_oe_n;
    assign pb5_o       = state_reg.p5;
    assign pb5_oe_n    = state_reg.p5_oe_n;
    assign irq_a_out_n = state_reg.irq_a_n;
    assign irq_b_out_n = state_reg.irq_b_n;
    assign fault_off_a = state_reg.f_a;
    assign fault_off_b = state_reg.f_b;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_strobe_sets_rx: assert property (
        (mode == HSPP_MODE_SINGLE) && str_ev && !state_reg.rx_ready
        |=> state_reg.rx_ready && state_reg.port_a_latch == $past(state_reg.pa_s2))
        else $error("strobe did not capture port A");
    a_rx_blocks_latch: assert property (
        (mode == HSPP_MODE_SINGLE) && state_reg.rx_ready && !wb_cyc_i
        |=> $stable(state_reg.port_a_latch))
        else $error("latch changed while receive flag set");
    a_pal_read_clears: assert property (
        rd_pal && (mode == HSPP_MODE_SINGLE) && !set_rx |=> !state_reg.rx_ready)
        else $error("latch read did not clear receive flag");
    a_ready_level: assert property (
        (mode == HSPP_MODE_SINGLE) && pulse_sel && $stable(state_reg.port_cfg)
        && (state_next.port_cfg == state_reg.port_cfg)
        |=> pb6_o == (pol ? !$past(state_reg.rx_ready) : $past(state_reg.rx_ready)))
        else $error("ready output does not track receive flag");
    a_strobe_out_pulse: assert property (
        (mode == HSPP_MODE_MULTI) && rd_pal && $stable(state_reg.port_cfg)
        |=> ##1 (pb6_o == pol) [*8])
        else $error("strobe_out pulse missing or short");
    a_desired_value_a_clears_empty: assert property (
        wr_desired_value_a && (mode == HSPP_MODE_BIDIR) && !set_tx |=> !state_reg.tx_empty)
        else $error("desired value write did not clear empty flag");
    a_bidir_float: assert property (
        (mode == HSPP_MODE_BIDIR) && state_reg.pb4_s[1] |=> port_a_oe_n)
        else $error("port A driven while enable high");
    a_bidir_drive: assert property (
        (mode == HSPP_MODE_BIDIR) && !state_reg.pb4_s[1] && state_reg.pb7_s[1]
        |=> !port_a_oe_n && port_a_o == $past(state_reg.desired_value_a))
        else $error("port A not driven during slave read");
    a_write_end_latch: assert property (
        (mode == HSPP_MODE_BIDIR) && wr_end
        |=> state_reg.rx_ready && state_reg.port_a_latch == $past(state_reg.pa_s3))
        else $error("slave write not latched");
    a_irq_gate: assert property (
        !state_reg.irq_cfg[HSPP_ICR_ENA_BIT] |=> irq_a_out_n)
        else $error("irq A driven while disabled");
    a_rx_irq_path: assert property (
        state_reg.rx_ready && state_reg.irq_cfg[HSPP_ICR_RXIE_BIT] && state_reg.irq_cfg[HSPP_ICR_ENA_BIT]
        && $stable(state_reg.irq_cfg) |-> ##2 !irq_a_out_n)
        else $error("receive interrupt not raised");
    a_fault_single: assert property (
        mode == HSPP_MODE_SINGLE && $stable(mode) && (state_next.port_cfg[2:0] == mode)
        |=> fault_off_a == HSPP_FAULT_ALL && fault_off_b == HSPP_FAULT_B76)
        else $error("fault monitoring not disabled");

    c_single_capture: cover property ((mode == HSPP_MODE_SINGLE) && str_ev && !state_reg.rx_ready);
    c_bidir_write: cover property ((mode == HSPP_MODE_BIDIR) && wr_end);
    c_bidir_read: cover property ((mode == HSPP_MODE_BIDIR) && rd_end);
    c_multi_read: cover property ((mode == HSPP_MODE_MULTI) && rd_pal);

endmodule

// ---- tb/hspp_port_bench.sv ----
// Purpose: self-checking bench for the handshake parallel port
// Assumes: one wait state Wishbone slave, 50-cycle handshake pulses
// Notes:   status reads in the mode tasks are masked to the bits each mode defines
`timescale 1ns/1ps

module hspp_port_bench;
    import hspp_pkg::*;
    logic clk, rst, cyc, stb, we, ack, pa_oe_n, pb6, pb6_oe_n, pb5, pb5_oe_n, irq_a_n, irq_b_n;
    logic pb7, pb4;
    logic [7:0] adr, pa_i, pa_o, fa, fb, q;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    int n_errors = 0;
    int num_checks = 0;

    hspp_port u_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .port_a_i(pa_i), .port_a_o(pa_o),
        .port_a_oe_n(pa_oe_n), .pb7_i(pb7), .pb4_i(pb4), .pb6_o(pb6), .pb6_oe_n(pb6_oe_n), .pb5_o(pb5),
        .pb5_oe_n(pb5_oe_n), .irq_a_out_n(irq_a_n), .irq_b_out_n(irq_b_n), .fault_off_a(fa), .fault_off_b(fb));
    hspp_slave_model u_slave (.clk(clk), .port_a_o(pa_o), .port_a_oe_n(pa_oe_n), .port_a_i(pa_i),
        .pb7_i(pb7), .pb4_i(pb4));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic conclude();
        if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // classic single cycle; data taken at the edge that shows ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h00_0000, d}; sel <= 4'h1;
        do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
        if (n >= 50) n_errors++;
        r = rdat[7:0];
        cyc <= 1'b0; stb <= 1'b0; @(posedge clk);
    endtask

    // single read: capture, blocking while full, latch read, irq gating
    task automatic t_single();
        wb(1, HSPP_OFF_PORT_CFG, 8'h3D, q); wb(1, HSPP_OFF_IRQ_CFG, 8'h12, q); repeat (4) @(posedge clk);
        chk(pb6, 1'b1); chk(fa, 8'hFF); chk(fb, 8'hC0);
        u_slave.strobe_wr(8'hA5, 8'h0F); repeat (4) @(posedge clk);
        wb(0, HSPP_OFF_STATUS, 8'h00, q); chk(q & 8'h05, 8'h05);
        chk(pb6, 1'b0); chk(irq_a_n, 1'b0); chk(irq_b_n, 1'b1);
        u_slave.strobe_wr(8'h3C, 8'h3C);
        wb(0, HSPP_OFF_PAL, 8'h00, q); chk(q, 8'hA5);
        repeat (4) @(posedge clk);
        wb(0, HSPP_OFF_STATUS, 8'h00, q); chk(q & 8'h05, 8'h00);
        chk(pb6, 1'b1); chk(irq_a_n, 1'b1);
    endtask
    // falling edge capture and pulsed ready output
    task automatic t_pulse();
        wb(1, HSPP_OFF_PORT_CFG, 8'h15, q); repeat (4) @(posedge clk);
        u_slave.strobe_wr(8'h11, 8'h22);
        wb(0, HSPP_OFF_PAL, 8'h00, q); chk(q, 8'h22);
        repeat (8) @(posedge clk); chk(pb6, 1'b1);
        repeat (50) @(posedge clk); chk(pb6, 1'b0);
    endtask
    // bidirectional host write, slave read, slave write
    task automatic t_bidir();
        wb(1, HSPP_OFF_PORT_CFG, 8'h17, q); wb(1, HSPP_OFF_DESIRED_VALUE_A, 8'h5A, q); repeat (4) @(posedge clk);
        wb(0, HSPP_OFF_STATUS, 8'h00, q); chk(q & 8'h02, 8'h00); chk(pb5, 1'b1);
        u_slave.bus_rd(q); chk(q, 8'h5A); chk(pa_oe_n, 1'b1);
        wb(0, HSPP_OFF_STATUS, 8'h00, q); chk(q & 8'h02, 8'h02); chk(pb5, 1'b0);
        u_slave.bus_wr(8'h77);
        wb(0, HSPP_OFF_STATUS, 8'h00, q); chk(q & 8'h01, 8'h01); chk(pb6, 1'b0);
        wb(0, HSPP_OFF_PAL, 8'h00, q); chk(q, 8'h77);
        wb(0, HSPP_OFF_STATUS, 8'h00, q); chk(q & 8'h01, 8'h00);
        wb(0, 8'h20, 8'h00, q); chk(q, 8'h00);
    endtask
    // output mode, interlocked, falling strobe after the slave took the byte
    task automatic t_out();
        wb(1, HSPP_OFF_PORT_CFG, 8'h36, q); wb(1, HSPP_OFF_DESIRED_VALUE_A, 8'hC3, q); repeat (4) @(posedge clk);
        chk(pa_o, 8'hC3); chk(pa_oe_n, 1'b0); chk(pb5, 1'b1);
        chk(fa, 8'hFF); chk(fb, 8'hC0);
        u_slave.strobe_wr(8'h00, 8'h00); repeat (4) @(posedge clk);
        wb(0, HSPP_OFF_STATUS, 8'h00, q); chk(q & 8'h02, 8'h02);
        chk(pb5, 1'b0); chk(pa_oe_n, 1'b1);
    endtask
    // multiple read: live pins returned, one read emits a strobe_out pulse
    task automatic t_multi();
        wb(1, HSPP_OFF_PORT_CFG, 8'h14, q); u_slave.drive(8'h96); repeat (70) @(posedge clk);
        chk(pb6, 1'b0);
        wb(0, HSPP_OFF_PAL, 8'h00, q); chk(q, 8'h96);
        repeat (4) @(posedge clk); chk(pb6, 1'b1);
        repeat (60) @(posedge clk); chk(pb6, 1'b0);
    endtask

    initial begin
        rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; wdat = 32'h0000_0000;
        repeat (4) @(posedge clk);
        rst <= 1'b0; @(posedge clk);
        chk(pb6_oe_n, 1'b1);
        wb(0, HSPP_OFF_STATUS, 8'h00, q); chk(q, 8'h02);
        t_single(); t_pulse(); t_bidir(); t_out(); t_multi();
        conclude();
    end
    // longest path is well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        conclude();
    end
endmodule

// ---- tb/hspp_slave_model.sv ----
// Purpose: slave controller on port A and the port B handshake pins
// Assumes: pins change just after a rising clk edge, held >=2 cycles a phase
// Notes:   a released port A shows the inverse of its last level, never a stale copy
`timescale 1ns/1ps

module hspp_slave_model (
    input  wire logic       clk,
    input  wire logic [7:0] port_a_o,
    input  wire logic       port_a_oe_n,
    output logic      [7:0] port_a_i,
    output logic            pb7_i,
    output logic            pb4_i
);
    logic [7:0] drv;
    logic       drv_en;
    logic [7:0] last;

    initial begin
        drv    = 8'h00;
        drv_en = 1'b0;
        pb7_i  = 1'b0;
        pb4_i  = 1'b1;
    end
    // resolved wire; floating bus keeps toggling so no stale value passes
    always_comb port_a_i = !port_a_oe_n ? port_a_o : (drv_en ? drv : ~last);
    always_ff @(posedge clk) last <= port_a_i;

    // strobe write: d1 stands at the rising strobe edge, d2 at the falling one
    task automatic strobe_wr(input logic [7:0] d1, input logic [7:0] d2);
        drv <= d1; drv_en <= 1'b1; repeat (4) @(posedge clk);
        pb7_i <= 1'b1; repeat (4) @(posedge clk);
        drv <= d2; repeat (4) @(posedge clk);
        pb7_i <= 1'b0; repeat (4) @(posedge clk);
        drv_en <= 1'b0; repeat (4) @(posedge clk);
    endtask
    // plain data on port A, no strobe, for the converter case
    task automatic drive(input logic [7:0] d);
        drv <= d; drv_en <= 1'b1; repeat (4) @(posedge clk);
    endtask
    // sram-like write, ended by enable rising
    task automatic bus_wr(input logic [7:0] d);
        drv <= d; drv_en <= 1'b1; pb4_i <= 1'b0; repeat (4) @(posedge clk);
        pb4_i <= 1'b1; repeat (2) @(posedge clk);
        drv_en <= 1'b0; repeat (4) @(posedge clk);
    endtask
    // sram-like read; the device must drive the wire before enable rises
    task automatic bus_rd(output logic [7:0] d);
        pb7_i <= 1'b1; pb4_i <= 1'b0; repeat (6) @(posedge clk);
        d = port_a_i;
        pb4_i <= 1'b1; repeat (4) @(posedge clk);
        pb7_i <= 1'b0; repeat (4) @(posedge clk);
    endtask
endmodule
